//--- src/arr_params.svh
// offsets, bit positions, reset values and tick counts of the receiver
`ifndef ARR_PARAMS_SVH
`define ARR_PARAMS_SVH

// register byte offsets
`define ARR_ADR_STATUS   8'h00
`define ARR_ADR_CTRL1    8'h04
`define ARR_ADR_CTRL2    8'h08
`define ARR_ADR_CTRL3    8'h0C
`define ARR_ADR_DATA     8'h10
`define ARR_ADR_BAUD     8'h14

// status_one bits
`define ARR_ST_PE        0
`define ARR_ST_FE        1
`define ARR_ST_NF        2
`define ARR_ST_OR        3
`define ARR_ST_IDLE      4
`define ARR_ST_RBF       5

// control_one bits
`define ARR_C1_NINE      0
`define ARR_C1_WAKE      1
`define ARR_C1_QUIET_COUNT_ORIGIN      2
`define ARR_C1_PEN       3
`define ARR_C1_PTY       4
`define ARR_C1_EN        5

// control_two bits
`define ARR_C2_RWU       0
`define ARR_C2_RIE       1
`define ARR_C2_QUIET_IRQ_ENABLE      2

// control_three bits
`define ARR_C3_PARITY_IRQ_ENABLE      0
`define ARR_C3_FRAMING_IRQ_ENABLE      1
`define ARR_C3_NOISE_IRQ_ENABLE      2
`define ARR_C3_OVERRUN_IRQ_ENABLE      3
`define ARR_C3_R8        4

// reset values
`define ARR_C1_RST       6'h00
`define ARR_C2_RST       3'h0
`define ARR_C3_RST       4'h0
`define ARR_BAUD_RST     16'h0043

// oversample tick positions within one bit
`define ARR_RT_1         5'h01
`define ARR_RT_3         5'h03
`define ARR_RT_5         5'h05
`define ARR_RT_7         5'h07
`define ARR_RT_8         5'h08
`define ARR_RT_9         5'h09
`define ARR_RT_10        5'h0A
`define ARR_RT_LATE      5'h0C
`define ARR_RT_16        5'h10

// stop bit index and quiet length in ticks
`define ARR_STOP8        4'h9
`define ARR_STOP9        4'hA
`define ARR_QUIET8       8'hA0
`define ARR_QUIET9       8'hB0

`endif

//--- src/arr_pkg.sv
// types shared by the receiver
package arr_pkg;

    typedef enum logic [0:0] {
        ARR_HUNT = 1'b0,
        ARR_RECV = 1'b1
    } arr_state_e;

    typedef logic [7:0]  arr_adr_t;
    typedef logic [31:0] arr_word_t;

endpackage

//--- src/arr_top.sv
// receive side of the asynchronous serial interface with wishbone registers
`timescale 1ns/1ns
`include "arr_params.svh"

// Behaviour
// - late start samples only flag noise
// - stop bit by majority, disagreement flags noise
// - missing stop one sets framing error
// - break character sets framing error
// - framing error appears with buffer full
// - resync tick counter on valid falling edges
// - stop sampled 16 ticks per bit plus 10
// - standby bit suppresses receiver interrupts
// - address mark clears standby, fills buffer
// - idle wake clears standby, no flags set
// - origin bit chooses where quiet counting starts
// - standby set on quiet line may wake
// - buffer full flag with gated interrupt
// - quiet flag after 10/11 ones, gated interrupt
// - overrun keeps old data, drops new
// - noise flag with its own enable
// - framing error interrupt gated by enable
// - parity mismatch flag gated by enable
// - wait mode runs on, bus locked, wakes
// - stop mode halts receiver, keeps registers
// - tick runs at sixteen times baud
// - origin bit one means after stop
// - selector one means address mark wake
module arr_top
    import arr_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           rst_n,
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire arr_pkg::arr_adr_t  wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire arr_pkg::arr_word_t wb_dat_i,
    output arr_pkg::arr_word_t  wb_dat_o,
    output logic                wb_ack_o,
    input  wire logic           serial_input_pin,
    input  wire logic           wait_mode,
    input  wire logic           stop_mode,
    output logic                rx_irq,
    output logic                err_irq,
    output logic                wake_request
);
    import arr_pkg::*;

    // bus side
    logic             wb_ack_r;
    arr_word_t        wb_dat_r;
    logic [5:0]       ctrl1_r;
    logic [5:0]       ctrl1_nxt;
    logic [2:0]       ctrl2_r;
    logic [2:0]       ctrl2_nxt;
    logic [3:0]       ctrl3_r;
    logic [15:0]      baud_r;
    logic [5:0]       flags_r;
    logic [5:0]       flags_nxt;
    logic [5:0]       flag_set;
    logic [5:0]       flag_clr;
    logic [8:0]       data_r;

    // receiver
    logic             rx_s1_r;
    logic             rx_s2_r;
    logic [15:0]      div_r;
    logic [15:0]      div_nxt;
    arr_state_e       state_r;
    arr_state_e       state_nxt;
    logic [4:0]       rt_r;
    logic [4:0]       rt_nxt;
    logic [3:0]       bit_r;
    logic [3:0]       bit_nxt;
    logic [2:0]       hist_r;
    logic [1:0]       smp_r;
    logic [1:0]       ones_r;
    logic [1:0]       ones_nxt;
    logic [8:0]       shift_r;
    logic             nf_acc_r;
    logic             last_one_r;
    logic [7:0]       quiet_r;
    logic [7:0]       quiet_nxt;
    logic             armed_r;
    logic             rx_irq_r;
    logic             err_irq_r;
    logic             wake_r;

    wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_r;
    // the core cannot reach the registers in wait mode
    wire bus_open = ~wait_mode;
    wire bus_wr   = bus_req & wb_we_i & wb_sel_i[0] & bus_open;
    wire bus_rd   = bus_req & ~wb_we_i & bus_open;
    wire hit_st   = wb_adr_i == `ARR_ADR_STATUS;
    wire hit_c1   = wb_adr_i == `ARR_ADR_CTRL1;
    wire hit_c2   = wb_adr_i == `ARR_ADR_CTRL2;
    wire hit_c3   = wb_adr_i == `ARR_ADR_CTRL3;
    wire hit_dat  = wb_adr_i == `ARR_ADR_DATA;
    wire hit_bd   = wb_adr_i == `ARR_ADR_BAUD;

    wire nine     = ctrl1_r[`ARR_C1_NINE];
    wire wake_sel = ctrl1_r[`ARR_C1_WAKE];
    wire quiet_count_origin     = ctrl1_r[`ARR_C1_QUIET_COUNT_ORIGIN];
    wire pen      = ctrl1_r[`ARR_C1_PEN];
    wire pty      = ctrl1_r[`ARR_C1_PTY];
    wire rx_en    = ctrl1_r[`ARR_C1_EN];
    wire receiver_standby      = ctrl2_r[`ARR_C2_RWU];

    // read data mux
    wire [7:0] st_rd = {2'h0, flags_r};
    wire [7:0] c3_rd = {3'h0, data_r[8], ctrl3_r};
    wire [15:0] rd_mux =
        hit_st  ? {8'h00, st_rd} :
        hit_c1  ? {10'h000, ctrl1_r} :
        hit_c2  ? {13'h0, ctrl2_r} :
        hit_c3  ? {8'h00, c3_rd} :
        hit_dat ? {8'h00, data_r[7:0]} :
        hit_bd  ? baud_r : 16'h0000;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack_r <= bus_req;
            wb_dat_r <= bus_rd ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end

    // oversample tick divider, halted in stop mode
    wire run  = rx_en & ~stop_mode;
    wire tick = run & (div_r == 16'h0000);
    assign div_nxt = (!run || tick) ? baud_r : div_r - 16'h0001;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            div_r   <= `ARR_BAUD_RST;
        end else begin
            rx_s1_r <= serial_input_pin;
            rx_s2_r <= rx_s1_r;
            div_r   <= div_nxt;
        end
    end

    wire smp = rx_s2_r;
    // sample history: three ones then a zero starts the search
    wire start_edge = (state_r == ARR_HUNT) & tick & ~smp &
                      (hist_r == 3'h7);
    wire in_rx  = (state_r == ARR_RECV);
    wire rtick  = in_rx & tick;
    wire at_rt  = rtick;
    wire rt3    = at_rt & (rt_r == `ARR_RT_3);
    wire rt5    = at_rt & (rt_r == `ARR_RT_5);
    wire rt7    = at_rt & (rt_r == `ARR_RT_7);
    wire rt8    = at_rt & (rt_r == `ARR_RT_8);
    wire rt9    = at_rt & (rt_r == `ARR_RT_9);
    wire rt10   = at_rt & (rt_r == `ARR_RT_10);
    wire rt16   = at_rt & (rt_r == `ARR_RT_16);
    wire [3:0] stop_idx = nine ? `ARR_STOP9 : `ARR_STOP8;

    // start verification at RT3, RT5, RT7
    wire vsmp = (rt3 | rt5 | rt7) & (bit_r == 4'h0) & smp;
    assign ones_nxt = ones_r + {1'b0, vsmp};
    wire start_fail = rt7 & (bit_r == 4'h0) & ones_nxt[1];
    wire start_nz   = rt7 & (bit_r == 4'h0) & (ones_nxt != 2'h0);

    // majority of RT8, RT9 and RT10
    wire s8  = smp_r[0];
    wire s9  = smp_r[1];
    wire maj = (s8 & s9) | (s8 & smp) | (s9 & smp);
    wire dis = ~(s8 & s9 & smp) & (s8 | s9 | smp);
    wire in_start = bit_r == 4'h0;
    wire in_stop  = bit_r == stop_idx;
    wire in_data  = ~in_start & ~in_stop;

    // late start samples never reject the start bit
    wire start_late_nz = rt10 & in_start & (s8 | s9 | smp);
    wire bit_nz   = rt10 & ~in_start & dis;
    // stop decided 9 or 10 bit times plus 10 ticks after start
    wire char_done = rt10 & in_stop;
    wire stop_zero = char_done & ~maj;

    // a 1 to 0 edge after a one bit realigns the tick count
    wire fall   = rtick & hist_r[0] & ~smp & last_one_r & ~in_start;
    wire early  = fall & (rt_r < `ARR_RT_8);
    wire late   = fall & (rt_r >= `ARR_RT_LATE) & ~in_stop;

    always_comb begin
        state_nxt = state_r;
        rt_nxt    = rt_r;
        bit_nxt   = bit_r;
        if (!run) begin
            state_nxt = ARR_HUNT;
        end else if (start_edge) begin
            state_nxt = ARR_RECV;
            rt_nxt    = `ARR_RT_1;
            bit_nxt   = 4'h0;
        end else if (start_fail || char_done) begin
            state_nxt = ARR_HUNT;
        end else if (late) begin
            rt_nxt  = `ARR_RT_1;
            bit_nxt = bit_r + 4'h1;
        end else if (early) begin
            rt_nxt  = `ARR_RT_1;
        end else if (rt16) begin
            rt_nxt  = `ARR_RT_1;
            bit_nxt = bit_r + 4'h1;
        end else if (rtick) begin
            rt_nxt  = rt_r + 5'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ARR_HUNT;
            rt_r    <= `ARR_RT_1;
            bit_r   <= 4'h0;
        end else begin
            state_r <= state_nxt;
            rt_r    <= rt_nxt;
            bit_r   <= bit_nxt;
        end
    end

    // sample history, vote samples, data shift and noise gathering
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_r     <= 3'h7;
            smp_r      <= 2'h3;
            ones_r     <= 2'h0;
            shift_r    <= 9'h000;
            nf_acc_r   <= 1'b0;
            last_one_r <= 1'b1;
        end else begin
            if (tick) begin
                hist_r <= {hist_r[1:0], smp};
            end
            if (start_edge) begin
                ones_r     <= 2'h0;
                nf_acc_r   <= 1'b0;
                last_one_r <= 1'b0;
                shift_r    <= 9'h000;
            end else begin
                ones_r <= ones_nxt;
                if (rt8) begin
                    smp_r[0] <= smp;
                end
                if (rt9) begin
                    smp_r[1] <= smp;
                end
                if (start_nz || start_late_nz || bit_nz) begin
                    nf_acc_r <= 1'b1;
                end
                if (rt10) begin
                    last_one_r <= maj;
                end
                if (rt10 && in_data) begin
                    shift_r <= {maj, shift_r[8:1]};
                end
            end
        end
    end

    // character assembled lsb first; 8-bit frames sit in the top bits
    wire [8:0] chr = nine ? shift_r : {1'b0, shift_r[8:1]};
    wire msb       = nine ? chr[8] : chr[7];
    wire par_bad   = pen & ((^chr) ^ pty);
    wire addr_wake = receiver_standby & wake_sel & msb;
    wire accept    = ~receiver_standby | addr_wake;
    wire take      = char_done & accept;
    wire load      = take & ~flags_r[`ARR_ST_RBF];
    wire ovr       = take & flags_r[`ARR_ST_RBF];

    // quiet detection: consecutive ones in ticks
    wire [7:0] quiet_thr = nine ? `ARR_QUIET9 : `ARR_QUIET8;
    // origin set: the count is held at zero until the stop bit is done
    wire hold_q  = quiet_count_origin & in_rx;
    always_comb begin
        quiet_nxt = quiet_r;
        if (!run) begin
            quiet_nxt = 8'h00;
        end else if (tick) begin
            if (!smp || hold_q) begin
                quiet_nxt = 8'h00;
            end else if (quiet_r != quiet_thr) begin
                quiet_nxt = quiet_r + 8'h01;
            end
        end
    end
    wire quiet_hit  = tick & smp & ~hold_q & armed_r &
                      (quiet_nxt == quiet_thr);
    // a standby receiver in idle mode wakes on any quiet line
    wire idle_wake  = receiver_standby & ~wake_sel & (quiet_r == quiet_thr);
    wire idle_flag  = quiet_hit & ~(receiver_standby & ~wake_sel);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_r <= 8'h00;
            armed_r <= 1'b0;
        end else begin
            quiet_r <= quiet_nxt;
            if (tick && !smp) begin
                armed_r <= 1'b1;
            end else if (quiet_hit) begin
                armed_r <= 1'b0;
            end
        end
    end

    // noise, framing and parity flags set together with buffer full so they are seen no later
    always_comb begin
        flag_set = 6'h00;
        flag_set[`ARR_ST_RBF]  = load;
        flag_set[`ARR_ST_FE]   = load & stop_zero;
        flag_set[`ARR_ST_NF]   = load & (nf_acc_r | bit_nz);
        flag_set[`ARR_ST_PE]   = load & par_bad;
        flag_set[`ARR_ST_OR]   = ovr;
        flag_set[`ARR_ST_IDLE] = idle_flag;
    end

    // write one to clear; reading the buffer clears buffer full
    always_comb begin
        flag_clr = 6'h00;
        if (bus_wr && hit_st) begin
            flag_clr = wb_dat_i[5:0];
        end
        if (bus_rd && hit_dat) begin
            flag_clr[`ARR_ST_RBF] = 1'b1;
        end
    end
    // a set in the clearing cycle wins
    assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

    // software write of the standby bit wins over a hardware wake
    always_comb begin
        ctrl2_nxt = ctrl2_r;
        if (addr_wake && char_done) begin
            ctrl2_nxt[`ARR_C2_RWU] = 1'b0;
        end
        if (idle_wake) begin
            ctrl2_nxt[`ARR_C2_RWU] = 1'b0;
        end
        if (bus_wr && hit_c2) begin
            ctrl2_nxt = wb_dat_i[2:0];
        end
    end
    assign ctrl1_nxt = (bus_wr && hit_c1) ? wb_dat_i[5:0] : ctrl1_r;

    // registers hold their contents across stop mode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_r <= `ARR_C1_RST;
            ctrl2_r <= `ARR_C2_RST;
            ctrl3_r <= `ARR_C3_RST;
            baud_r  <= `ARR_BAUD_RST;
            flags_r <= 6'h00;
            data_r  <= 9'h000;
        end else begin
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
            flags_r <= flags_nxt;
            if (bus_wr && hit_c3) begin
                ctrl3_r <= wb_dat_i[3:0];
            end
            if (bus_wr && hit_bd) begin
                baud_r <= wb_dat_i[15:0];
            end
            // overrun leaves the old character in place
            if (load) begin
                data_r <= {msb, chr[7:0]};
            end
        end
    end

    // interrupt requests, silenced in standby and in stop mode
    wire rx_req  = (flags_r[`ARR_ST_RBF] & ctrl2_r[`ARR_C2_RIE]) |
                   (flags_r[`ARR_ST_IDLE] & ctrl2_r[`ARR_C2_QUIET_IRQ_ENABLE]);
    wire err_req = (flags_r[`ARR_ST_OR] & ctrl3_r[`ARR_C3_OVERRUN_IRQ_ENABLE]) |
                   (flags_r[`ARR_ST_NF] & ctrl3_r[`ARR_C3_NOISE_IRQ_ENABLE]) |
                   (flags_r[`ARR_ST_FE] & ctrl3_r[`ARR_C3_FRAMING_IRQ_ENABLE]) |
                   (flags_r[`ARR_ST_PE] & ctrl3_r[`ARR_C3_PARITY_IRQ_ENABLE]);
    wire quiet_ok = ~receiver_standby & ~stop_mode;
    wire rx_nxt   = rx_req & quiet_ok;
    wire err_nxt  = err_req & quiet_ok;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_irq_r  <= 1'b0;
            err_irq_r <= 1'b0;
            wake_r    <= 1'b0;
        end else begin
            rx_irq_r  <= rx_nxt;
            err_irq_r <= err_nxt;
            wake_r    <= wait_mode & (rx_nxt | err_nxt);
        end
    end

    assign wb_ack_o     = wb_ack_r;
    assign wb_dat_o     = wb_dat_r;
    assign rx_irq       = rx_irq_r;
    assign err_irq      = err_irq_r;
    assign wake_request = wake_r;

endmodule

//--- testbench/arr_props.sv
// port assertions for the serial receiver
`timescale 1ns/1ns
module arr_props
    import arr_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire arr_pkg::arr_word_t wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic               wait_mode,
    input wire logic               stop_mode,
    input wire logic               rx_irq,
    input wire logic               err_irq,
    input wire logic               wake_request
);
    logic       req;
    logic [2:0] age_r;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // cycles since the last bus request, saturating
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            age_r <= 3'h7;
        else if (req)
            age_r <= 3'h0;
        else if (age_r != 3'h7)
            age_r <= age_r + 3'h1;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    AST_ACK_NEXT: assert property (req |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data outside ack");
    AST_WAIT_READ: assert property (
        req && !wb_we_i && wait_mode |=> wb_dat_o == '0)
        else $error("read in wait mode not zero");
    AST_WAKE: assert property (
        wake_request == ($past(wait_mode) && (rx_irq || err_irq)))
        else $error("wake request wrong");
    AST_STOP_QUIET: assert property (
        stop_mode |=> !rx_irq && !err_irq)
        else $error("interrupt in stop mode");
    AST_ERR_HOLD: assert property (
        $fell(err_irq) |-> age_r < 3'h4 || $past(stop_mode))
        else $error("error request dropped by itself");
    AST_RX_HOLD: assert property (
        $fell(rx_irq) |-> age_r < 3'h4 || $past(stop_mode))
        else $error("receive request dropped by itself");
endmodule
bind arr_top arr_props u_props (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .rx_irq(rx_irq), .err_irq(err_irq), .wake_request(wake_request)
);

//--- testbench/arr_tx_model.sv
// remote serial transmitter driving the receive line, 16 clocks a bit
`timescale 1ns/1ns
module arr_tx_model (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        send,
    input  wire logic [11:0] frame,
    input  wire logic [3:0]  nbits,
    input  wire logic [3:0]  glitch_at,
    output logic             line,
    output logic             busy
);
    logic [11:0] frame_r;
    logic [3:0]  idx_r;
    logic [3:0]  cnt_r;
    logic        wrap;
    logic [3:0]  idx_nxt;
    logic [3:0]  cnt_nxt;
    logic        bit_nxt;
    assign wrap = (cnt_r == 4'hF);
    assign cnt_nxt = cnt_r + 4'h1;
    assign idx_nxt = wrap ? idx_r + 4'h1 : idx_r;
    // one inverted clock in mid bit hits a single majority sample
    assign bit_nxt = frame_r[idx_nxt]
                     ^ (idx_nxt == glitch_at && cnt_nxt == 4'h8);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            line <= 1'b1;
        end else if (!busy) begin
            frame_r <= frame;
            idx_r <= 4'h0;
            cnt_r <= 4'h0;
            busy <= send;
            line <= send ? frame[0] : 1'b1;
        end else if (wrap && idx_r == nbits - 4'h1) begin
            busy <= 1'b0;
            line <= 1'b1;
        end else begin
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            line <= bit_nxt;
        end
    end
endmodule

//--- testbench/test_arr_top.sv
// self-checking bench for the serial receiver
`timescale 1ns/1ns
`include "arr_params.svh"
module test_arr_top;
    import arr_pkg::*;
    logic        core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        wait_mode, stop_mode, rx_irq, err_irq, wake_request;
    logic        line, send, busy, nine;
    arr_adr_t    wb_adr_i;
    arr_word_t   wb_dat_i, wb_dat_o, rd;
    logic [11:0] frame;
    logic [3:0]  glitch;
    int          n_fail, n_tests, t, k;
    logic [7:0]  r_dat [6] = '{8'h55, 8'hA3, 8'h00, 8'h81, 8'h3C, 8'hC6};
    logic        r_stp [6] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
    logic [3:0]  r_gl [6] = '{4'hF, 4'hF, 4'hF, 4'h9, 4'h0, 4'h3};
    logic [5:0]  r_st [6] = '{6'h20, 6'h22, 6'h22, 6'h24, 6'h24, 6'h24};
    arr_adr_t    ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h1C};
    arr_word_t   rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h43, 32'h0};
    arr_top dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .serial_input_pin(line),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .rx_irq(rx_irq),
        .err_irq(err_irq), .wake_request(wake_request));
    arr_tx_model u_tx (.core_clk(core_clk), .rst_n(rst_n), .send(send),
        .frame(frame), .nbits(nine ? 4'hB : 4'hA), .glitch_at(glitch),
        .line(line), .busy(busy));
    task automatic chk(input arr_word_t got, input arr_word_t exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h not %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic we, input arr_adr_t a, input arr_word_t d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        while (wb_ack_o !== 1'b1) @(posedge core_clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // t counts clocks from the start edge to the receive request
    task automatic tx(input logic [8:0] d, input logic s, input logic [3:0] g);
        int i;
        @(posedge core_clk);
        frame <= nine ? {1'b1, s, d, 1'b0} : {2'h3, s, d[7:0], 1'b0};
        glitch <= g;
        send <= 1'b1;
        @(posedge core_clk);
        send <= 1'b0;
        for (i = 0; i < 400 && rx_irq !== 1'b1; i++) @(posedge core_clk);
        t = i;
        // busy rises on the edge that takes send, so look one edge later
        do @(posedge core_clk); while (busy);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test;
    end
    initial begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wait_mode, stop_mode} = '0;
        {wb_adr_i, wb_dat_i, send, nine, frame, glitch} = '0;
        n_fail = 0;
        n_tests = 0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(1'b1, `ARR_ADR_BAUD, 32'h0);
        bus(1'b1, `ARR_ADR_CTRL1, 32'h20);
        bus(1'b1, `ARR_ADR_CTRL2, 32'h2);
        bus(1'b1, `ARR_ADR_CTRL3, 32'hE);
        for (k = 0; k < 6; k++) begin
            tx({1'b0, r_dat[k]}, r_stp[k], r_gl[k]);
            chk(t >= 155 && t <= 160, 1);
            bus(1'b0, `ARR_ADR_STATUS, 0);
            chk(rd & 32'h2F, r_st[k]);
            chk(err_irq, r_st[k][2:1] != 2'h0);
            chk(rx_irq, 1);
            bus(1'b0, `ARR_ADR_DATA, 0);
            chk(rd, r_dat[k]);
            bus(1'b1, `ARR_ADR_STATUS, 32'h3F);
            $display("row %0d done", k);
        end
        nine <= 1'b1;
        bus(1'b1, `ARR_ADR_CTRL1, 32'h21);
        tx(9'h155, 1'b1, 4'hF);
        chk(t >= 171 && t <= 176, 1);
        bus(1'b0, `ARR_ADR_CTRL3, 0);
        chk(rd, 32'h1E);
        bus(1'b0, `ARR_ADR_DATA, 0);
        chk(rd, 32'h55);
        nine <= 1'b0;
        bus(1'b1, `ARR_ADR_CTRL1, 32'h20);
        bus(1'b1, `ARR_ADR_STATUS, 32'h3F);
        $display("nine bit test done");
        bus(1'b1, `ARR_ADR_CTRL1, 32'h28);
        tx(9'h01, 1'b1, 4'hF);
        bus(1'b0, `ARR_ADR_STATUS, 0);
        chk(rd & 32'h2F, 32'h21);
        chk(err_irq, 1'b0);
        bus(1'b1, `ARR_ADR_CTRL3, 32'hF);
        @(posedge core_clk);
        chk(err_irq, 1'b1);
        bus(1'b1, `ARR_ADR_CTRL3, 32'hE);
        bus(1'b1, `ARR_ADR_CTRL1, 32'h20);
        bus(1'b1, `ARR_ADR_STATUS, 32'h3F);
        $display("parity test done");
        tx(9'h11, 1'b1, 4'hF);
        tx(9'h22, 1'b1, 4'hF);
        bus(1'b0, `ARR_ADR_STATUS, 0);
        chk(rd & 32'h2F, 32'h28);
        chk(err_irq, 1'b1);
        bus(1'b0, `ARR_ADR_DATA, 0);
        chk(rd, 32'h11);
        bus(1'b1, `ARR_ADR_STATUS, 32'h3F);
        $display("overrun test done");
        bus(1'b1, `ARR_ADR_CTRL1, 32'h22);
        bus(1'b1, `ARR_ADR_CTRL2, 32'h3);
        tx(9'h12, 1'b1, 4'hF);
        chk(t, 400);
        tx(9'h92, 1'b1, 4'hF);
        bus(1'b0, `ARR_ADR_CTRL2, 0);
        chk(rd, 32'h2);
        bus(1'b1, `ARR_ADR_CTRL2, 32'h3);
        repeat (3) @(posedge core_clk);
        chk(rx_irq, 1'b0);
        bus(1'b1, `ARR_ADR_CTRL2, 32'h2);
        bus(1'b0, `ARR_ADR_DATA, 0);
        chk(rd, 32'h92);
        $display("address wake test done");
        bus(1'b1, `ARR_ADR_CTRL1, 32'h20);
        bus(1'b1, `ARR_ADR_STATUS, 32'h3F);
        tx(9'hF0, 1'b1, 4'hF);
        bus(1'b1, `ARR_ADR_CTRL2, 32'h1);
        repeat (250) @(posedge core_clk);
        bus(1'b0, `ARR_ADR_CTRL2, 0);
        chk(rd, 32'h0);
        bus(1'b0, `ARR_ADR_STATUS, 0);
        chk(rd & 32'h10, 32'h0);
        bus(1'b1, `ARR_ADR_CTRL2, 32'h1);
        repeat (3) @(posedge core_clk);
        bus(1'b0, `ARR_ADR_CTRL2, 0);
        chk(rd, 32'h0);
        bus(1'b1, `ARR_ADR_CTRL2, 32'h4);
        bus(1'b1, `ARR_ADR_STATUS, 32'h3F);
        tx(9'h00, 1'b1, 4'hF);
        repeat (200) @(posedge core_clk);
        bus(1'b0, `ARR_ADR_STATUS, 0);
        chk(rd & 32'h30, 32'h30);
        chk(rx_irq, 1'b1);
        $display("idle wake test done");
        bus(1'b1, `ARR_ADR_STATUS, 32'h3F);
        tx(9'hFF, 1'b1, 4'hF);
        chk(t >= 176 && t <= 184, 1);
        bus(1'b1, `ARR_ADR_CTRL1, 32'h24);
        bus(1'b1, `ARR_ADR_STATUS, 32'h3F);
        tx(9'hFF, 1'b1, 4'hF);
        chk(t >= 315 && t <= 323, 1);
        bus(1'b1, `ARR_ADR_CTRL1, 32'h20);
        $display("quiet origin test done");
        bus(1'b1, `ARR_ADR_CTRL2, 32'h2);
        bus(1'b1, `ARR_ADR_STATUS, 32'h3F);
        wait_mode <= 1'b1;
        bus(1'b1, `ARR_ADR_CTRL2, 32'h0);
        bus(1'b0, `ARR_ADR_CTRL1, 0);
        chk(rd, 32'h0);
        tx(9'h5A, 1'b1, 4'hF);
        chk(wake_request, 1'b1);
        wait_mode <= 1'b0;
        bus(1'b0, `ARR_ADR_CTRL2, 0);
        chk(rd, 32'h2);
        stop_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(rx_irq, 1'b0);
        bus(1'b0, `ARR_ADR_CTRL1, 0);
        chk(rd, 32'h20);
        stop_mode <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(rx_irq, 1'b1);
        $display("low power test done");
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        for (k = 0; k < 6; k++) begin
            bus(1'b0, ra[k], 0);
            chk(rd, rv[k]);
        end
        $display("reset test done");
        stop_test;
    end
endmodule
